// ### design/tas_reach.v
// setpoint reached detector, rising or falling approach
`timescale 1ns/1ps
module tas_reach #(
    parameter W = 16
) (
    // measurement and setpoint
    input  wire [W-1:0] meas_in,
    input  wire [W-1:0] sp_in,
    input  wire         rising_in,
    // result
    output wire         hit_out
);
    assign hit_out = rising_in ? (meas_in >= sp_in) : (meas_in <= sp_in);
endmodule // tas_reach

// ### design/tas_regs.vh
// register map, field layout, reset values and fixed counts of the auto start and throttle block
`ifndef TAS_REGS_VH
`define TAS_REGS_VH

// ****************************************
// word indices on the register bus
// ****************************************
`define TAS_A_CTRL      6'h00
`define TAS_A_STAT      6'h01
`define TAS_A_SPD       6'h02
`define TAS_A_FSS       6'h03
`define TAS_A_FMD       6'h04
`define TAS_A_LSS       6'h05
`define TAS_A_LMD       6'h06
`define TAS_A_TSS       6'h07
`define TAS_A_FPI       6'h08
`define TAS_A_FD        6'h09
`define TAS_A_LPI       6'h0a
`define TAS_A_LD        6'h0b
`define TAS_A_CD        6'h0c
`define TAS_A_CDL       6'h0d
`define TAS_A_SPDR      6'h0e
`define TAS_A_SCHED     6'h10
`define TAS_A_SCHED_END 6'h30

// ****************************************
// control fields and encodings
// ****************************************
`define TAS_F_SS        1:0
`define TAS_F_TS        3:2
`define TAS_B_PID       4
`define TAS_B_FPROP     5
`define TAS_B_LPROP     6
`define TAS_B_FIN       7
`define TAS_B_LFILL     8
`define TAS_SRC_NONE    2'h0
`define TAS_SRC_FLOW    2'h1
`define TAS_SRC_LEVEL   2'h2
`define TAS_SRC_TEMP    2'h3
`define TAS_LO          15:0
`define TAS_HI          31:16
`define TAS_DAY_DAILY   4'h7
`define TAS_SLOT_DAYS   2'h0
`define TAS_SLOT_TSTART 2'h1
`define TAS_SLOT_TSTOP  2'h2

// ****************************************
// reset values
// ****************************************
`define TAS_RST_CTRL    9'h000
`define TAS_RST_SPD     32'h070804b0
`define TAS_RST_ZERO    32'h00000000
`define TAS_RST_TSS     32'h00200020
`define TAS_RST_PI      32'h051f051f
`define TAS_RST_D       16'h0042
`define TAS_RST_DAYS    8'h88

// ****************************************
// time format and fixed counts
// ****************************************
`define TAS_T_SEC       5:0
`define TAS_T_MIN       13:8
`define TAS_T_HR        20:16
`define TAS_SEC_PER_MIN 17'h0003c
`define TAS_SEC_PER_HR  17'h00e10
`define TAS_TEMP_BIAS   16'h8000
`define TAS_FRAC_FULL   9'h100
`define TAS_DIV_STEPS   4'h8
`define TAS_ACC_INT     31:16

`endif

// ### design/tas_throttle.v
// auto start/stop, schedule, countdown and throttle logic with an avalon-mm register slave
`timescale 1ns/1ps
`include "tas_regs.vh"
module tas_throttle #(
    parameter STEP = 16'h0001
) (
    // clock and reset
    input  wire        clk_sys_in,
    input  wire        rst_in,
    // avalon-mm slave
    input  wire [5:0]  avs_address_in,
    input  wire        avs_read_in,
    input  wire        avs_write_in,
    input  wire [31:0] avs_writedata_in,
    output wire [31:0] avs_readdata_out,
    output wire        avs_waitrequest_out,
    // process measurements and time base
    input  wire [15:0] flow_in,
    input  wire [15:0] level_in,
    input  wire [15:0] temp_in,
    input  wire        sample_in,
    input  wire        sec_tick_in,
    input  wire [2:0]  dow_in,
    input  wire [20:0] tod_in,
    // engine demand
    output wire        auto_start_out,
    output wire        auto_stop_out,
    output wire        run_out,
    output wire [15:0] speed_demand_out
);
    localparam ST_IDLE  = 3'b001;
    localparam ST_DIV   = 3'b010;
    localparam ST_APPLY = 3'b100;

    reg  [8:0]  ctrl_q;
    reg  [31:0] spd_q, fss_q, fmd_q, lss_q, lmd_q, tss_q, fpi_q, lpi_q;
    reg  [15:0] fd_q, ld_q;
    reg  [20:0] cd_q;
    reg  [7:0]  day_q [0:7];
    reg  [20:0] tstart_q [0:7];
    reg  [20:0] tstop_q [0:7];
    reg         wait_q;
    reg  [31:0] rdata_q, rdata_d;
    reg         run_q, start_p_q, stop_p_q, cd_act_q;
    reg  [16:0] cd_left_q;
    reg  [2:0]  state_q;
    reg  [3:0]  div_cnt_q;
    reg  [16:0] rem_q;
    reg  [8:0]  frac_q;
    reg  signed [16:0] err_q, e1_q, e2_q;
    reg  [31:0] acc_q;
    reg  [15:0] spd_out_q;
    integer     k;

    // ****************************************
    // register bus
    // ****************************************
    // one wait cycle on every access keeps read data registered
    wire       req     = avs_read_in | avs_write_in;
    wire       wr      = avs_write_in & ~wait_q;
    wire [5:0] s_off   = avs_address_in - `TAS_A_SCHED;
    wire [2:0] s_slot  = s_off[4:2];
    wire [1:0] s_sub   = s_off[1:0];
    wire       s_hit   = (avs_address_in >= `TAS_A_SCHED) &&
                         (avs_address_in < `TAS_A_SCHED_END);
    wire       is_temp = ctrl_q[`TAS_F_SS] == `TAS_SRC_TEMP;
    wire       in_db;

    always @(posedge clk_sys_in)
    begin
        if (rst_in)
            wait_q <= 1'b1;
        else
            wait_q <= ~(req & wait_q);
    end

    always @*
    begin
        rdata_d = `TAS_RST_ZERO;
        if (s_hit)
        begin
            case (s_sub)
                `TAS_SLOT_DAYS:   rdata_d = {24'h000000, day_q[s_slot]};
                `TAS_SLOT_TSTART: rdata_d = {11'h000, tstart_q[s_slot]};
                `TAS_SLOT_TSTOP:  rdata_d = {11'h000, tstop_q[s_slot]};
                default:          rdata_d = `TAS_RST_ZERO;
            endcase
        end
        else
        begin
            case (avs_address_in)
                `TAS_A_CTRL: rdata_d = {23'h000000, ctrl_q};
                `TAS_A_STAT: rdata_d = {29'h00000000, in_db, cd_act_q, run_q};
                `TAS_A_SPD:  rdata_d = spd_q;
                `TAS_A_FSS:  rdata_d = fss_q;
                `TAS_A_FMD:  rdata_d = fmd_q;
                `TAS_A_LSS:  rdata_d = lss_q;
                `TAS_A_LMD:  rdata_d = lmd_q;
                `TAS_A_TSS:  rdata_d = tss_q;
                `TAS_A_FPI:  rdata_d = fpi_q;
                `TAS_A_FD:   rdata_d = {16'h0000, fd_q};
                `TAS_A_LPI:  rdata_d = lpi_q;
                `TAS_A_LD:   rdata_d = {16'h0000, ld_q};
                `TAS_A_CD:   rdata_d = {11'h000, cd_q};
                `TAS_A_CDL:  rdata_d = {15'h0000, cd_left_q};
                `TAS_A_SPDR: rdata_d = {16'h0000, spd_out_q};
                default:     rdata_d = `TAS_RST_ZERO;
            endcase
        end
    end

    always @(posedge clk_sys_in)
    begin
        if (rst_in)
            rdata_q <= `TAS_RST_ZERO;
        else if (avs_read_in & wait_q)
            rdata_q <= rdata_d;
    end

    always @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            ctrl_q <= `TAS_RST_CTRL;
            spd_q  <= `TAS_RST_SPD;
            fss_q  <= `TAS_RST_ZERO;
            fmd_q  <= `TAS_RST_ZERO;
            lss_q  <= `TAS_RST_ZERO;
            lmd_q  <= `TAS_RST_ZERO;
            tss_q  <= `TAS_RST_TSS;
            fpi_q  <= `TAS_RST_PI;
            lpi_q  <= `TAS_RST_PI;
            fd_q   <= `TAS_RST_D;
            ld_q   <= `TAS_RST_D;
            cd_q   <= 21'h000000;
            for (k = 0; k < 8; k = k + 1)
            begin
                day_q[k]    <= `TAS_RST_DAYS;
                tstart_q[k] <= 21'h000000;
                tstop_q[k]  <= 21'h000000;
            end
        end
        else if (wr)
        begin
            if (s_hit)
            begin
                case (s_sub)
                    `TAS_SLOT_DAYS:   day_q[s_slot]    <= avs_writedata_in[7:0];
                    `TAS_SLOT_TSTART: tstart_q[s_slot] <= avs_writedata_in[20:0];
                    `TAS_SLOT_TSTOP:  tstop_q[s_slot]  <= avs_writedata_in[20:0];
                    default:          ;
                endcase
            end
            else
            begin
                case (avs_address_in)
                    `TAS_A_CTRL: ctrl_q <= avs_writedata_in[8:0];
                    `TAS_A_SPD:  spd_q  <= avs_writedata_in;
                    `TAS_A_FSS:  fss_q  <= avs_writedata_in;
                    `TAS_A_FMD:  fmd_q  <= avs_writedata_in;
                    `TAS_A_LSS:  lss_q  <= avs_writedata_in;
                    `TAS_A_LMD:  lmd_q  <= avs_writedata_in;
                    `TAS_A_TSS:  if (is_temp) tss_q <= avs_writedata_in;
                    `TAS_A_FPI:  fpi_q  <= avs_writedata_in;
                    `TAS_A_FD:   fd_q   <= avs_writedata_in[15:0];
                    `TAS_A_LPI:  lpi_q  <= avs_writedata_in;
                    `TAS_A_LD:   ld_q   <= avs_writedata_in[15:0];
                    `TAS_A_CD:   cd_q   <= avs_writedata_in[20:0];
                    default:     ;
                endcase
            end
        end
    end

    // ****************************************
    // start and stop setpoint detection
    // ****************************************
    // temperature is two's complement; flipping the sign bit makes unsigned compares valid
    wire [15:0] temp_b  = temp_in ^ `TAS_TEMP_BIAS;
    wire [15:0] tstrt_b = tss_q[`TAS_LO] ^ `TAS_TEMP_BIAS;
    wire [15:0] tstop_b = tss_q[`TAS_HI] ^ `TAS_TEMP_BIAS;
    wire        fin     = ctrl_q[`TAS_B_FIN];
    wire        lfill   = ctrl_q[`TAS_B_LFILL];
    wire [95:0] r_meas  = {temp_b, temp_b, level_in, level_in, flow_in, flow_in};
    wire [95:0] r_sp    = {tstop_b, tstrt_b, lss_q, fss_q};
    // start approach: out and empty start rising, in and fill start falling
    wire [5:0]  r_rise  = {1'b1, 1'b0, lfill, ~lfill, fin, ~fin};
    wire [5:0]  r_hit;

    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1)
        begin : g_reach
            tas_reach #(.W(16)) u_reach (
                .meas_in   (r_meas[16*g+15:16*g]),
                .sp_in     (r_sp[16*g+15:16*g]),
                .rising_in (r_rise[g]),
                .hit_out   (r_hit[g])
            );
        end
    endgenerate

    reg start_hit, stop_hit;
    always @*
    begin
        case (ctrl_q[`TAS_F_SS])
            `TAS_SRC_FLOW:  {stop_hit, start_hit} = r_hit[1:0];
            `TAS_SRC_LEVEL: {stop_hit, start_hit} = r_hit[3:2];
            `TAS_SRC_TEMP:  {stop_hit, start_hit} = r_hit[5:4];
            default:        {stop_hit, start_hit} = 2'b00;
        endcase
    end

    // ****************************************
    // weekly schedule slots
    // ****************************************
    wire [7:0] sch_start, sch_stop;
    generate
        for (g = 0; g < 8; g = g + 1)
        begin : g_slot
            wire [3:0] sd = day_q[g][3:0];
            wire [3:0] pd = day_q[g][7:4];
            // day codes above daily mean off and never match
            assign sch_start[g] = sec_tick_in && (tstart_q[g] == tod_in) &&
                                  (sd == `TAS_DAY_DAILY || sd == {1'b0, dow_in});
            assign sch_stop[g]  = sec_tick_in && (tstop_q[g] == tod_in) &&
                                  (pd == `TAS_DAY_DAILY || pd == {1'b0, dow_in});
        end
    endgenerate

    // ****************************************
    // run control and countdown
    // ****************************************
    wire [16:0] cd_total = cd_q[`TAS_T_HR] * `TAS_SEC_PER_HR +
                           cd_q[`TAS_T_MIN] * `TAS_SEC_PER_MIN + {11'h000, cd_q[`TAS_T_SEC]};
    wire cd_exp   = cd_act_q & sec_tick_in & (cd_left_q == 17'h00001);
    wire ev_start = ~run_q & (start_hit | (|sch_start));
    // stop wins when both conditions coincide while running
    wire ev_stop  = run_q & (stop_hit | (|sch_stop) | cd_exp);

    always @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            run_q     <= 1'b0;
            start_p_q <= 1'b0;
            stop_p_q  <= 1'b0;
            cd_act_q  <= 1'b0;
            cd_left_q <= 17'h00000;
        end
        else
        begin
            start_p_q <= ev_start;
            stop_p_q  <= ev_stop;
            if (ev_start)
            begin
                run_q     <= 1'b1;
                cd_act_q  <= cd_total != 17'h00000;
                cd_left_q <= cd_total;
            end
            else if (ev_stop)
            begin
                run_q    <= 1'b0;
                cd_act_q <= 1'b0;
            end
            else if (cd_act_q & sec_tick_in)
                cd_left_q <= cd_left_q - 17'h00001;
        end
    end

    // ****************************************
    // throttle source selection and error
    // ****************************************
    wire [1:0]  tsrc  = ctrl_q[`TAS_F_TS];
    wire        t_lvl = tsrc == `TAS_SRC_LEVEL;
    // temperature is no throttle source, so its code leaves speed alone
    wire        t_on  = run_q & (tsrc == `TAS_SRC_FLOW || t_lvl);
    wire [15:0] t_m   = t_lvl ? level_in : flow_in;
    wire [15:0] t_sp  = t_lvl ? lmd_q[`TAS_LO] : fmd_q[`TAS_LO];
    wire [15:0] t_db  = t_lvl ? lmd_q[`TAS_HI] : fmd_q[`TAS_HI];
    wire [15:0] t_st  = t_lvl ? lss_q[`TAS_LO] : fss_q[`TAS_LO];
    wire [15:0] t_sto = t_lvl ? lss_q[`TAS_HI] : fss_q[`TAS_HI];
    wire        t_up  = t_lvl ? lfill : fin;
    wire        t_pr  = t_lvl ? ctrl_q[`TAS_B_LPROP] : ctrl_q[`TAS_B_FPROP];
    wire [15:0] kp    = t_lvl ? lpi_q[`TAS_LO] : fpi_q[`TAS_LO];
    wire [15:0] ki    = t_lvl ? lpi_q[`TAS_HI] : fpi_q[`TAS_HI];
    wire [15:0] kd    = t_lvl ? ld_q : fd_q;
    wire        pid   = ctrl_q[`TAS_B_PID];
    wire        sp0   = t_sp == 16'h0000;

    // positive error always means speed should rise
    wire signed [16:0] diff = $signed({1'b0, t_sp}) - $signed({1'b0, t_m});
    wire signed [16:0] err  = t_up ? diff : -diff;
    wire        [16:0] aerr = diff[16] ? -diff : diff;
    assign in_db = aerr <= {1'b0, t_db};

    wire [15:0] num = (t_m > t_sto) ? t_m - t_sto : t_sto - t_m;
    wire [15:0] den = (t_st > t_sto) ? t_st - t_sto : t_sto - t_st;

    // ****************************************
    // pid terms and clamp
    // ****************************************
    wire signed [17:0] d1 = {err_q[16], err_q} - {e1_q[16], e1_q};
    wire signed [18:0] d2 = {{2{err_q[16]}}, err_q} - {e1_q[16], e1_q, 1'b0} +
                            {{2{e2_q[16]}}, e2_q};
    wire signed [35:0] pt = $signed({1'b0, kp}) * d1;
    wire signed [35:0] it = $signed({1'b0, ki}) * err_q;
    wire signed [35:0] dt = $signed({1'b0, kd}) * d2;
    wire signed [39:0] acc_s = $signed({8'h00, acc_q});
    wire signed [39:0] pid_c = acc_s + pt + it + dt;
    wire signed [39:0] stp_c = err_q[16] ? acc_s - $signed({8'h00, STEP, 16'h0000})
                                         : acc_s + $signed({8'h00, STEP, 16'h0000});
    wire [15:0] smin  = spd_q[`TAS_LO];
    wire [15:0] smax  = spd_q[`TAS_HI];
    wire [24:0] span  = (smax - smin) * frac_q;
    wire [15:0] prop  = smin + span[23:8];
    wire signed [39:0] lo_c = $signed({8'h00, smin, 16'h0000});
    wire signed [39:0] hi_c = $signed({8'h00, smax, 16'h0000});

    reg signed [39:0] cand;
    always @*
    begin
        cand = acc_s;
        if (state_q == ST_APPLY)
        begin
            if (pid && sp0)
                cand = t_pr ? $signed({8'h00, prop, 16'h0000}) : hi_c;
            else if (in_db)
                cand = acc_s;
            else if (!pid)
                cand = stp_c;
            else
                cand = pid_c;
        end
        if (cand > hi_c)
            cand = hi_c;
        else if (cand < lo_c)
            cand = lo_c;
    end

    // ****************************************
    // throttle update sequencer
    // ****************************************
    wire [16:0] rem_sh = {rem_q[15:0], 1'b0};
    always @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            state_q   <= ST_IDLE;
            div_cnt_q <= 4'h0;
            rem_q     <= 17'h00000;
            frac_q    <= 9'h000;
            err_q     <= 17'sh00000;
            e1_q      <= 17'sh00000;
            e2_q      <= 17'sh00000;
            acc_q     <= `TAS_RST_ZERO;
            spd_out_q <= 16'h0000;
        end
        else
        begin
            acc_q     <= cand[31:0];
            spd_out_q <= acc_q[`TAS_ACC_INT];
            case (state_q)
                ST_IDLE:
                begin
                    if (t_on && sample_in)
                    begin
                        err_q     <= err;
                        rem_q     <= {1'b0, num};
                        div_cnt_q <= 4'h0;
                        frac_q    <= `TAS_FRAC_FULL;
                        // linear scale only needs the divide when inside the start-stop span
                        if (pid && sp0 && t_pr && num < den)
                            state_q <= ST_DIV;
                        else
                            state_q <= ST_APPLY;
                    end
                end
                ST_DIV:
                begin
                    if (rem_sh >= {1'b0, den})
                    begin
                        rem_q  <= rem_sh - {1'b0, den};
                        frac_q <= {frac_q[7:0], 1'b1};
                    end
                    else
                    begin
                        rem_q  <= rem_sh;
                        frac_q <= {frac_q[7:0], 1'b0};
                    end
                    div_cnt_q <= div_cnt_q + 4'h1;
                    if (div_cnt_q == `TAS_DIV_STEPS - 4'h1)
                        state_q <= ST_APPLY;
                end
                ST_APPLY:
                begin
                    e2_q    <= e1_q;
                    e1_q    <= err_q;
                    state_q <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
            // a stop drops any update in flight, so demand falls to minimum two cycles after run drops
            if (!run_q)
            begin
                state_q <= ST_IDLE;
                acc_q   <= {smin, 16'h0000};
                e1_q    <= 17'sh00000;
                e2_q    <= 17'sh00000;
            end
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign avs_readdata_out    = rdata_q;
    assign avs_waitrequest_out = wait_q;
    assign auto_start_out      = start_p_q;
    assign auto_stop_out       = stop_p_q;
    assign run_out             = run_q;
    assign speed_demand_out    = spd_out_q;

endmodule // tas_throttle

// ### verification/tas_chk.sv
// port checker for the auto start and throttle block
`timescale 1ns/1ps
module tas_chk (
    input wire        clk_sys_in, rst_in, avs_read_in, avs_write_in,
    input wire        avs_waitrequest_out, auto_start_out, auto_stop_out, run_out,
    input wire [31:0] avs_readdata_out,
    input wire [15:0] speed_demand_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    chk_wait_one: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
        |=> !avs_waitrequest_out) else $error("access not answered");
    chk_wait_pulse: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("wait low too long");
    chk_rdata_hold: assert property (avs_waitrequest_out |-> $stable(avs_readdata_out))
        else $error("read data moved");
    chk_start_pulse: assert property (auto_start_out |=> !auto_start_out)
        else $error("start pulse long");
    chk_start_run: assert property (auto_start_out |-> run_out && !$past(run_out))
        else $error("start while running");
    chk_stop_run: assert property (auto_stop_out |-> !run_out && $past(run_out))
        else $error("stop while stopped");
    chk_run_cause: assert property ($changed(run_out) |-> auto_start_out || auto_stop_out)
        else $error("run moved alone");
    chk_speed_clamp: assert property ($past(!rst_in, 3) |->
        speed_demand_out >= 16'h04b0 && speed_demand_out <= 16'h0708) else $error("speed out of range");
    chk_idle_min: assert property ((!run_out)[*4] |-> speed_demand_out == 16'h04b0)
        else $error("idle speed not minimum");
    cover property (auto_start_out);
    cover property (auto_stop_out && $past(run_out, 2));
    cover property (run_out && $changed(speed_demand_out));
endmodule // tas_chk
bind tas_throttle tas_chk u_chk (.*);

// ### verification/tas_throttle_tb_top.sv
// self-checking bench for the auto start and throttle block
`timescale 1ns/1ps
`include "tas_regs.vh"
module tas_throttle_tb_top;
    reg         clk_sys_in, rst_in, avs_read_in, avs_write_in;
    reg  [5:0]  avs_address_in;
    reg  [31:0] avs_writedata_in, got;
    reg  [15:0] flow_in, level_in, temp_in, spd;
    reg  [2:0]  dow_in = 3'h0;
    reg  [20:0] tod_in = 21'h000001;
    wire [31:0] avs_readdata_out;
    wire        avs_waitrequest_out, sample_in, sec_tick_in, auto_start_out, auto_stop_out, run_out;
    wire [15:0] speed_demand_out;
    integer     mismatches = 0, num_checks = 0, cyc = 0;
    tas_xdcr XDCR (.clk_in(clk_sys_in), .rst_in(rst_in), .sample_out(sample_in),
        .sec_tick_out(sec_tick_in));
    tas_throttle DUT (.*);
    initial
    begin
        clk_sys_in = 1'b0;
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end
    task chk(input [31:0] g, input [31:0] e);
    begin
        num_checks = num_checks + 1;
        if (g !== e)
        begin
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
            mismatches = mismatches + 1;
        end
    end
    endtask
    task bus(input w, input [5:0] a, input [31:0] d);
    begin
        @(posedge clk_sys_in);
        avs_read_in <= !w;
        avs_write_in <= w;
        avs_address_in <= a;
        avs_writedata_in <= d;
        do @(posedge clk_sys_in); while (avs_waitrequest_out !== 1'b0);
        got = avs_readdata_out;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
    end
    endtask
    task rd(input [5:0] a, input [31:0] e);
    begin
        bus(1'b0, a, 32'h0);
        chk(got, e);
    end
    endtask
    // pulse and run level are compared at the same edge
    task evt(input stop);
    integer n;
    begin
        n = 0;
        do begin @(posedge clk_sys_in); n = n + 1; end
        while (((stop ? auto_stop_out : auto_start_out) !== 1'b1) && n < 400);
        chk({30'h0, (stop ? auto_stop_out : auto_start_out), run_out}, {30'h0, 1'b1, !stop});
    end
    endtask
    task settle(input integer c);
    begin
        repeat (c) @(posedge clk_sys_in);
        spd = speed_demand_out;
    end
    endtask
    task complete_run;
    begin
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    end
    endtask
    always @(posedge clk_sys_in)
    begin
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            mismatches = mismatches + 1;
            complete_run;
        end
    end
    initial
    begin
        rst_in = 1'b1;
        {avs_read_in, avs_write_in, avs_address_in, avs_writedata_in} = 0;
        {flow_in, level_in, temp_in} = {16'h0, 16'h0, 16'h0028};
        repeat (8) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        rd(`TAS_A_CTRL, 32'h0);
        rd(`TAS_A_SPD, `TAS_RST_SPD);
        rd(`TAS_A_FSS, 32'h0);
        rd(`TAS_A_FMD, 32'h0);
        rd(`TAS_A_LSS, 32'h0);
        rd(`TAS_A_LMD, 32'h0);
        rd(`TAS_A_TSS, `TAS_RST_TSS);
        rd(`TAS_A_FPI, `TAS_RST_PI);
        rd(`TAS_A_LD, {16'h0, `TAS_RST_D});
        rd(`TAS_A_SCHED + 6'h1c, {24'h0, `TAS_RST_DAYS});
        rd(`TAS_A_SCHED + 6'h1, 32'h0);
        rd(6'h0f, 32'h0);
        bus(1'b1, `TAS_A_TSS, 32'h00320020);
        rd(`TAS_A_TSS, `TAS_RST_TSS);
        bus(1'b1, `TAS_A_FSS, 32'h00320064);
        bus(1'b1, `TAS_A_FMD, 32'h000a0064);
        bus(1'b1, `TAS_A_CTRL, 32'h5);
        flow_in <= 16'h0078;
        evt(1'b0);
        settle(60);
        chk({31'h0, spd > 16'h04b0}, 32'h1);
        flow_in <= 16'h0064;
        settle(24);
        settle(50);
        chk(speed_demand_out, spd);
        flow_in <= 16'h0028;
        evt(1'b1);
        bus(1'b1, `TAS_A_FSS, 32'h00c80032);
        bus(1'b1, `TAS_A_CTRL, 32'h85);
        evt(1'b0);
        settle(60);
        chk({31'h0, spd > 16'h04b0}, 32'h1);
        flow_in <= 16'h00c8;
        evt(1'b1);
        bus(1'b1, `TAS_A_CTRL, 32'h3);
        bus(1'b1, `TAS_A_TSS, 32'h00320020);
        rd(`TAS_A_TSS, 32'h00320020);
        bus(1'b1, `TAS_A_CD, 32'h3);
        temp_in <= 16'h001e;
        evt(1'b0);
        evt(1'b1);
        evt(1'b0);
        temp_in <= 16'h003c;
        evt(1'b1);
        bus(1'b1, `TAS_A_LSS, 32'h00320064);
        bus(1'b1, `TAS_A_CTRL, 32'h2);
        level_in <= 16'h0070;
        evt(1'b0);
        level_in <= 16'h0020;
        evt(1'b1);
        // pid, then full speed at zero setpoint, then proportional on flow with no countdown
        bus(1'b1, `TAS_A_CD, 32'h0);
        bus(1'b1, `TAS_A_FSS, 32'h00320064);
        bus(1'b1, `TAS_A_CTRL, 32'h15);
        flow_in <= 16'h0078;
        evt(1'b0);
        settle(60);
        chk({31'h0, spd > 16'h04b0}, 32'h1);
        bus(1'b1, `TAS_A_FMD, 32'h0);
        settle(30);
        chk(speed_demand_out, 32'h00000708);
        bus(1'b1, `TAS_A_CTRL, 32'h35);
        flow_in <= 16'h004b;
        settle(40);
        chk(speed_demand_out, 32'h000005dc);
        flow_in <= 16'h0028;
        evt(1'b1);
        // schedule slot 0: start sunday at tod 1, stop daily at tod 2
        bus(1'b1, `TAS_A_CTRL, 32'h0);
        bus(1'b1, `TAS_A_SCHED + 6'h1, 32'h1);
        bus(1'b1, `TAS_A_SCHED + 6'h2, 32'h2);
        bus(1'b1, `TAS_A_SCHED, 32'h70);
        evt(1'b0);
        tod_in <= 21'h000002;
        evt(1'b1);
        complete_run;
    end
endmodule // tas_throttle_tb_top

// ### verification/tas_xdcr.sv
// stand-in for the process side: sample strobe and compressed second tick
`timescale 1ns/1ps
module tas_xdcr #(
    parameter SAMPLE_GAP = 12,
    parameter SEC_GAP    = 20
) (
    input  wire clk_in,
    input  wire rst_in,
    output reg  sample_out,
    output reg  sec_tick_out
);
    integer cnt_q;
    // gap of 10 or more, so no strobe lands on an update in flight
    always @(posedge clk_in)
    begin
        cnt_q        <= rst_in ? 0 : cnt_q + 1;
        sample_out   <= !rst_in && (cnt_q % SAMPLE_GAP == 0);
        sec_tick_out <= !rst_in && (cnt_q % SEC_GAP == 7);
    end
endmodule // tas_xdcr
